// ### verilog/acis_pkg.sv
// package: register map, field layout and codes for the converter input select block
// Functional notes
// RULE1 - comparator/op-amp enable repurposes analog inputs 0-7
// RULE2 - op-amp output routed when its mode bit is 1
// RULE3 - positive code 11110 selects temperature diode
// RULE4 - 11010 op-amp 3, 11001 op-amp 2
// RULE5 - codes 00000-01111 select pins 0-15
// RULE6 - negative bit: 1 pin 1, 0 low reference
// RULE7 - bits 14-13 and 6-5 read zero
// RULE8 - control step copies literal into select register
// RULE9 - literal read-only while sequencer enabled and started
// RULE10 - add step adds adjust to literal
// RULE11 - reserved positive codes leave input unconnected
// RULE12 - mux A field uses mux B code table
package acis_pkg;
  localparam int ACIS_AW = 4;
  localparam int ACIS_DW = 16;
  // register offsets (word index on the plain port)
  localparam logic [ACIS_AW-1:0] ACIS_OFF_CH0_SEL = 4'h0;
  localparam logic [ACIS_AW-1:0] ACIS_OFF_ADJUST = 4'h1;
  localparam logic [ACIS_AW-1:0] ACIS_OFF_LITERAL = 4'h2;
  localparam logic [ACIS_AW-1:0] ACIS_OFF_SEQ_CTRL = 4'h3;
  localparam logic [ACIS_AW-1:0] ACIS_OFF_ROUTE = 4'h4;
  localparam logic [ACIS_AW-1:0] ACIS_OFF_STATUS = 4'h5;
  // channel-0 select register layout
  localparam logic [ACIS_DW-1:0] ACIS_CH0_WMASK = 16'h9F9F;
  localparam int ACIS_NEG_B_BIT = 15;
  localparam int ACIS_NEG_A_BIT = 7;
  localparam int ACIS_POS_B_LSB = 8;
  localparam int ACIS_POS_A_LSB = 0;
  localparam int ACIS_POS_W = 5;
  // sequencer control register bits
  localparam int ACIS_SEQ_EN_BIT = 0;
  localparam int ACIS_SEQ_START_BIT = 1;
  // route register bits: op-amp mode 1..3, comparator/op-amp block enable
  localparam int ACIS_OPAMP_ROUTE_SELECT_LSB = 0;
  localparam int ACIS_ANA_TAKEN_BIT = 3;
  localparam logic [ACIS_DW-1:0] ACIS_RESET_VAL = 16'h0000;
  localparam logic [ACIS_DW-1:0] ACIS_UNMAPPED = 16'h0000;
  // positive input codes
  localparam logic [4:0] ACIS_POS_PIN_MAX = 5'h0F;
  localparam logic [4:0] ACIS_POS_OA1 = 5'h18;
  localparam logic [4:0] ACIS_POS_OA2 = 5'h19;
  localparam logic [4:0] ACIS_POS_OA3 = 5'h1A;
  localparam logic [4:0] ACIS_POS_TEMP = 5'h1E;
  localparam logic [4:0] ACIS_POS_OPEN = 5'h1F;
  localparam logic [3:0] ACIS_PIN_AN0 = 4'h0;
  localparam logic [3:0] ACIS_PIN_AN1 = 4'h1;
  localparam logic [3:0] ACIS_PIN_AN3 = 4'h3;
  localparam logic [3:0] ACIS_PIN_AN6 = 4'h6;
  localparam logic [3:0] ACIS_PIN_SHARED_MAX = 4'h7;
  // routed source kinds
  typedef enum logic [2:0] {
    ACIS_SRC_NONE = 3'b000,
    ACIS_SRC_PIN = 3'b001,
    ACIS_SRC_OPAMP = 3'b010,
    ACIS_SRC_TEMP = 3'b011,
    ACIS_SRC_VREFL = 3'b100
  } acis_src_e;
  // sequencer step commands
  typedef enum logic [1:0] {
    ACIS_STEP_NONE = 2'b00,
    ACIS_STEP_CTRL = 2'b01,
    ACIS_STEP_ADD = 2'b10
  } acis_step_e;
endpackage : acis_pkg

// ### verilog/acis_pos_decode.sv
// positive-input code decoder shared by both sample multiplexers
module acis_pos_decode
  import acis_pkg::*;
(
  // selection
  input wire logic [ACIS_POS_W-1:0] code,
  input wire logic [2:0] opamp_route_select,
  input wire logic analog_taken,
  // routed source
  output acis_src_e src,
  output logic [3:0] idx
);
  always_comb begin
    src = ACIS_SRC_NONE; // RULE11
    idx = 4'h0;
    if (code <= ACIS_POS_PIN_MAX) begin
      idx = code[3:0]; // RULE5
      src = ACIS_SRC_PIN;
      // a shared pin taken by an enabled op-amp is disconnected
      if (analog_taken && idx <= ACIS_PIN_SHARED_MAX) begin // RULE1
        if ((idx == ACIS_PIN_AN3 && opamp_route_select[0]) ||
            (idx == ACIS_PIN_AN0 && opamp_route_select[1]) ||
            (idx == ACIS_PIN_AN6 && opamp_route_select[2])) begin
          src = ACIS_SRC_NONE;
        end
      end
    end else if (code == ACIS_POS_OA1) begin
      idx = ACIS_PIN_AN3;
      src = opamp_route_select[0] ? ACIS_SRC_OPAMP : ACIS_SRC_PIN; // RULE2
    end else if (code == ACIS_POS_OA2) begin
      idx = ACIS_PIN_AN0;
      src = opamp_route_select[1] ? ACIS_SRC_OPAMP : ACIS_SRC_PIN; // RULE4
    end else if (code == ACIS_POS_OA3) begin
      idx = ACIS_PIN_AN6;
      src = opamp_route_select[2] ? ACIS_SRC_OPAMP : ACIS_SRC_PIN; // RULE4
    end else if (code == ACIS_POS_TEMP) begin
      src = ACIS_SRC_TEMP; // RULE3
    end
  end
endmodule : acis_pos_decode

// ### verilog/acis_top.sv
// converter channel-0 input select with sequencer literal and adjust registers
module acis_top
  import acis_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ACIS_AW-1:0] reg_addr,
  input wire logic [ACIS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ACIS_DW-1:0] reg_rdata,
  // sequencer step commands, same clock
  input wire logic [1:0] seq_step,
  // multiplexer A routing
  output acis_src_e mux_a_pos_src,
  output logic [3:0] mux_a_pos_idx,
  output acis_src_e mux_a_neg_src,
  // multiplexer B routing
  output acis_src_e mux_b_pos_src,
  output logic [3:0] mux_b_pos_idx,
  output acis_src_e mux_b_neg_src
);
  typedef struct packed {
    logic [ACIS_DW-1:0] ch0_sel;
    logic [ACIS_DW-1:0] adjust;
    logic [ACIS_DW-1:0] literal;
    logic seq_enable;
    logic seq_start;
    logic [2:0] opamp_route_select;
    logic analog_taken;
    logic [ACIS_DW-1:0] rdata;
    acis_src_e a_pos_src;
    logic [3:0] a_pos_idx;
    acis_src_e a_neg_src;
    acis_src_e b_pos_src;
    logic [3:0] b_pos_idx;
    acis_src_e b_neg_src;
  } acis_state_s;

  acis_state_s st;
  acis_state_s next_st;
  acis_src_e dec_a_src;
  acis_src_e dec_b_src;
  logic [3:0] dec_a_idx;
  logic [3:0] dec_b_idx;
  logic seq_running;
  acis_step_e step;

  assign step = acis_step_e'(seq_step);
  assign seq_running = st.seq_enable && st.seq_start;

  // mux A reuses the mux B code table
  acis_pos_decode u_dec_a (
    .code(st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W]), // RULE12
    .opamp_route_select(st.opamp_route_select),
    .analog_taken(st.analog_taken),
    .src(dec_a_src),
    .idx(dec_a_idx)
  );
  acis_pos_decode u_dec_b (
    .code(st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W]),
    .opamp_route_select(st.opamp_route_select),
    .analog_taken(st.analog_taken),
    .src(dec_b_src),
    .idx(dec_b_idx)
  );

  // register writes, sequencer steps, read mux and registered routing
  always_comb begin
    next_st = st;
    if (reg_wr) begin
      if (reg_addr == ACIS_OFF_CH0_SEL) begin
        next_st.ch0_sel = reg_wdata & ACIS_CH0_WMASK; // RULE7
      end else if (reg_addr == ACIS_OFF_ADJUST) begin
        next_st.adjust = reg_wdata;
      end else if (reg_addr == ACIS_OFF_LITERAL) begin
        // software loses the literal while steps execute
        if (!seq_running) begin // RULE9
          next_st.literal = reg_wdata;
        end
      end else if (reg_addr == ACIS_OFF_SEQ_CTRL) begin
        next_st.seq_enable = reg_wdata[ACIS_SEQ_EN_BIT];
        next_st.seq_start = reg_wdata[ACIS_SEQ_START_BIT];
      end else if (reg_addr == ACIS_OFF_ROUTE) begin
        next_st.opamp_route_select = reg_wdata[ACIS_OPAMP_ROUTE_SELECT_LSB +: 3];
        next_st.analog_taken = reg_wdata[ACIS_ANA_TAKEN_BIT];
      end
    end
    // step commands act only while running; they win over software writes
    if (seq_running) begin
      case (step)
        ACIS_STEP_CTRL: begin
          next_st.ch0_sel = st.literal & ACIS_CH0_WMASK; // RULE8
        end
        ACIS_STEP_ADD: begin
          next_st.literal = st.literal + st.adjust; // RULE10
        end
        default: begin
        end
      endcase
    end
    // read data stands one cycle after the strobe only
    next_st.rdata = ACIS_RESET_VAL;
    if (reg_rd) begin
      if (reg_addr == ACIS_OFF_CH0_SEL) begin
        next_st.rdata = st.ch0_sel; // RULE7
      end else if (reg_addr == ACIS_OFF_ADJUST) begin
        next_st.rdata = st.adjust;
      end else if (reg_addr == ACIS_OFF_LITERAL) begin
        next_st.rdata = st.literal;
      end else if (reg_addr == ACIS_OFF_SEQ_CTRL) begin
        next_st.rdata[ACIS_SEQ_EN_BIT] = st.seq_enable;
        next_st.rdata[ACIS_SEQ_START_BIT] = st.seq_start;
      end else if (reg_addr == ACIS_OFF_ROUTE) begin
        next_st.rdata[ACIS_OPAMP_ROUTE_SELECT_LSB +: 3] = st.opamp_route_select;
        next_st.rdata[ACIS_ANA_TAKEN_BIT] = st.analog_taken;
      end else if (reg_addr == ACIS_OFF_STATUS) begin
        next_st.rdata[ACIS_SEQ_EN_BIT] = seq_running;
      end else begin
        next_st.rdata = ACIS_UNMAPPED;
      end
    end
    // routing outputs follow the select register one cycle later
    next_st.a_pos_src = dec_a_src;
    next_st.a_pos_idx = dec_a_idx;
    next_st.b_pos_src = dec_b_src;
    next_st.b_pos_idx = dec_b_idx;
    next_st.a_neg_src = st.ch0_sel[ACIS_NEG_A_BIT] ? ACIS_SRC_PIN : ACIS_SRC_VREFL; // RULE6
    next_st.b_neg_src = st.ch0_sel[ACIS_NEG_B_BIT] ? ACIS_SRC_PIN : ACIS_SRC_VREFL; // RULE6
  end

  // the whole state in one register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign mux_a_pos_src = st.a_pos_src;
  assign mux_a_pos_idx = st.a_pos_idx;
  assign mux_a_neg_src = st.a_neg_src;
  assign mux_b_pos_src = st.b_pos_src;
  assign mux_b_pos_idx = st.b_pos_idx;
  assign mux_b_neg_src = st.b_neg_src;

  // assertions
  sequence s_lit_write;
    reg_wr && reg_addr == ACIS_OFF_LITERAL && !seq_running && !(step == ACIS_STEP_ADD);
  endsequence
  sequence s_ctrl_step;
    seq_running && step == ACIS_STEP_CTRL;
  endsequence

  a_ch0_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    (st.ch0_sel & ~ACIS_CH0_WMASK) == 16'h0000)
    else $error("unimplemented select bits set");
  a_literal_locked: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    reg_wr && reg_addr == ACIS_OFF_LITERAL && seq_running && step == ACIS_STEP_NONE
    |=> $stable(st.literal))
    else $error("literal written while running");
  a_literal_write: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    s_lit_write |=> st.literal == $past(reg_wdata))
    else $error("literal write lost");
  a_ctrl_copy: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    s_ctrl_step |=> st.ch0_sel == ($past(st.literal) & ACIS_CH0_WMASK))
    else $error("control step did not copy literal");
  a_add_step: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    seq_running && step == ACIS_STEP_ADD
    |=> st.literal == 16'($past(st.literal) + $past(st.adjust)))
    else $error("add step wrong sum");
  a_temp_route: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] == ACIS_POS_TEMP
    |=> mux_b_pos_src == ACIS_SRC_TEMP)
    else $error("temperature diode not routed");
  a_pin_route: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W] <= ACIS_POS_PIN_MAX && !st.analog_taken
    |=> mux_a_pos_src == ACIS_SRC_PIN && mux_a_pos_idx == $past(st.ch0_sel[3:0]))
    else $error("pin code misrouted");
  a_neg_route: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    ##1 (mux_a_neg_src == ACIS_SRC_PIN) == $past(st.ch0_sel[ACIS_NEG_A_BIT]))
    else $error("negative input misrouted");
  a_opamp_route: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] == ACIS_POS_OA3
    |=> (mux_b_pos_src == ACIS_SRC_OPAMP) == $past(st.opamp_route_select[2]))
    else $error("op-amp route wrong");
  a_reserved_open: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W] == ACIS_POS_OPEN
    |=> mux_a_pos_src == ACIS_SRC_NONE)
    else $error("open code connected");

  // read port: data stand one cycle after the strobe, zero otherwise
  sequence s_read_ch0;
    reg_rd && reg_addr == ACIS_OFF_CH0_SEL;
  endsequence

  sequence s_ch0_write;
    reg_wr && reg_addr == ACIS_OFF_CH0_SEL && !(seq_running && step == ACIS_STEP_CTRL);
  endsequence

  sequence s_literal_quiet;
    !(reg_wr && reg_addr == ACIS_OFF_LITERAL && !seq_running) &&
      !(seq_running && step == ACIS_STEP_ADD);
  endsequence

  sequence s_select_quiet;
    !(reg_wr && reg_addr == ACIS_OFF_CH0_SEL) && !(seq_running && step == ACIS_STEP_CTRL);
  endsequence

  // a stale read value would be taken as fresh by the next reader
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd
    |=> reg_rdata == ACIS_RESET_VAL)
    else $error("read data left standing");

  // select register reads back what it holds
  a_rd_ch0: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    s_read_ch0
    |=> reg_rdata == $past(st.ch0_sel))
    else $error("select read wrong");

  // unimplemented select bits always read zero
  a_rd_unimpl: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    s_read_ch0
    |=> (reg_rdata & ~ACIS_CH0_WMASK) == 16'h0000)
    else $error("unimplemented bits read as one");

  // literal reads back, also while locked
  a_rd_literal: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    reg_rd && reg_addr == ACIS_OFF_LITERAL
    |=> reg_rdata == $past(st.literal))
    else $error("literal read wrong");

  // adjust reads back
  a_rd_adjust: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    reg_rd && reg_addr == ACIS_OFF_ADJUST
    |=> reg_rdata == $past(st.adjust))
    else $error("adjust read wrong");

  // status shows whether steps execute
  a_rd_status: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    reg_rd && reg_addr == ACIS_OFF_STATUS
    |=> reg_rdata == {15'h0000, $past(seq_running)})
    else $error("status read wrong");

  // route register reads back its four bits
  a_rd_route: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    reg_rd && reg_addr == ACIS_OFF_ROUTE
    |=> reg_rdata == {12'h000, $past(st.analog_taken), $past(st.opamp_route_select)})
    else $error("route read wrong");

  // unmapped words read as the fixed filler
  a_rd_unmapped: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr > ACIS_OFF_STATUS
    |=> reg_rdata == ACIS_UNMAPPED)
    else $error("unmapped read not filler");

  // software write lands masked unless a control step wins
  a_ch0_write: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    s_ch0_write
    |=> st.ch0_sel == ($past(reg_wdata) & ACIS_CH0_WMASK))
    else $error("select write lost");

  // adjust is never locked
  a_adjust_write: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    reg_wr && reg_addr == ACIS_OFF_ADJUST
    |=> st.adjust == $past(reg_wdata))
    else $error("adjust write lost");

  // enable and start bits follow the write
  a_seq_ctrl_write: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    reg_wr && reg_addr == ACIS_OFF_SEQ_CTRL
    |=> st.seq_enable == $past(reg_wdata[ACIS_SEQ_EN_BIT]) &&
      st.seq_start == $past(reg_wdata[ACIS_SEQ_START_BIT]))
    else $error("sequencer control write lost");

  // op-amp mode bits follow the write
  a_route_write: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    reg_wr && reg_addr == ACIS_OFF_ROUTE
    |=> st.opamp_route_select == $past(reg_wdata[ACIS_OPAMP_ROUTE_SELECT_LSB +: 3]))
    else $error("route write lost");

  // literal changes only by an unlocked write or an add step
  a_literal_quiet: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    s_literal_quiet
    |=> $stable(st.literal))
    else $error("literal changed by itself");

  // select changes only by a write or a control step
  a_select_quiet: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    s_select_quiet
    |=> $stable(st.ch0_sel))
    else $error("select changed by itself");

  // a copied literal reaches the negative routing two cycles on
  a_ctrl_neg_follow: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    s_ctrl_step ##1 st.ch0_sel[ACIS_NEG_A_BIT]
    |=> mux_a_neg_src == ACIS_SRC_PIN)
    else $error("copied select not routed");

  // temperature diode on multiplexer A too
  a_temp_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W] == ACIS_POS_TEMP
    |=> mux_a_pos_src == ACIS_SRC_TEMP)
    else $error("temperature diode not routed on A");

  // op-amp 1 shares pin 3
  a_opamp1_route: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] == ACIS_POS_OA1
    |=> (mux_b_pos_src == ACIS_SRC_OPAMP) == $past(st.opamp_route_select[0]) &&
      mux_b_pos_idx == ACIS_PIN_AN3)
    else $error("op-amp 1 route wrong");

  // op-amp 2 shares pin 0
  a_opamp2_route: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] == ACIS_POS_OA2
    |=> (mux_b_pos_src == ACIS_SRC_OPAMP) == $past(st.opamp_route_select[1]) &&
      mux_b_pos_idx == ACIS_PIN_AN0)
    else $error("op-amp 2 route wrong");

  // op-amp 3 shares pin 6
  a_opamp3_idx: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] == ACIS_POS_OA3
    |=> mux_b_pos_idx == ACIS_PIN_AN6)
    else $error("op-amp 3 index wrong");

  // multiplexer A decodes op-amp codes the same way
  a_opamp_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W] == ACIS_POS_OA3
    |=> (mux_a_pos_src == ACIS_SRC_OPAMP) == $past(st.opamp_route_select[2]))
    else $error("op-amp route wrong on A");

  // a pin taken by its op-amp is not also routed as a pin
  a_shared_taken: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    st.ch0_sel[ACIS_POS_A_LSB +: ACIS_POS_W] == {1'b0, ACIS_PIN_AN3} &&
      st.analog_taken && st.opamp_route_select[0]
    |=> mux_a_pos_src == ACIS_SRC_NONE)
    else $error("taken pin still routed");

  // lower reserved band leaves the input open
  a_reserved_low: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] > ACIS_POS_PIN_MAX &&
      st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] < ACIS_POS_OA1
    |=> mux_b_pos_src == ACIS_SRC_NONE)
    else $error("reserved code connected");

  // upper reserved band leaves the input open
  a_reserved_high: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] > ACIS_POS_OA3 &&
      st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] < ACIS_POS_TEMP
    |=> mux_b_pos_src == ACIS_SRC_NONE)
    else $error("reserved code connected on B");

  // multiplexer B negative input follows its bit
  a_neg_route_b: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    1'b1
    |=> (mux_b_neg_src == ACIS_SRC_PIN) == $past(st.ch0_sel[ACIS_NEG_B_BIT]))
    else $error("negative input misrouted on B");

  // plain pin codes on multiplexer B
  a_pin_route_b: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    st.ch0_sel[ACIS_POS_B_LSB +: ACIS_POS_W] <= ACIS_POS_PIN_MAX && !st.analog_taken
    |=> mux_b_pos_src == ACIS_SRC_PIN && mux_b_pos_idx == $past(st.ch0_sel[ACIS_POS_B_LSB +: 4]))
    else $error("pin code misrouted on B");
endmodule : acis_top

// ### test/acis_seq_model.sv
// sequencer partner model: issues one step command, promptly or after a gap
module acis_seq_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [3:0] gap,
  // step command towards the block
  output logic [1:0] seq_step,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [1:0] held;
  // a command lasts one cycle; the gap stands in for a slow sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      held <= 2'h0;
      busy <= 1'h0;
      seq_step <= 2'h0;
    end else begin
      seq_step <= 2'h0;
      if (go && !busy) begin
        busy <= 1'h1;
        cnt <= gap;
        held <= kind;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        seq_step <= held;
        busy <= 1'h0;
      end
    end
  end
endmodule : acis_seq_model

// ### test/tb_top.sv
// self-checking bench for the channel-0 input select block
module tb_top
  import acis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [ACIS_AW-1:0] reg_addr = '0;
  logic [ACIS_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic go = 1'h0;
  logic [1:0] kind = 2'h0;
  logic [3:0] gap = 4'h0;
  logic [ACIS_DW-1:0] reg_rdata;
  logic [1:0] seq_step;
  logic busy;
  acis_src_e mux_a_pos_src, mux_a_neg_src, mux_b_pos_src, mux_b_neg_src;
  logic [3:0] mux_a_pos_idx, mux_b_pos_idx;
  int errors = 0;
  int cmp_count = 0;
  logic [15:0] d, raw, lit, adj, sel;
  logic [3:0] rt;
  // 250 MHz
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  acis_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_step(seq_step),
    .mux_a_pos_src(mux_a_pos_src), .mux_a_pos_idx(mux_a_pos_idx), .mux_a_neg_src(mux_a_neg_src),
    .mux_b_pos_src(mux_b_pos_src), .mux_b_pos_idx(mux_b_pos_idx), .mux_b_neg_src(mux_b_neg_src));
  acis_seq_model u_seq (.core_clk(core_clk), .rst(rst), .go(go), .kind(kind), .gap(gap),
    .seq_step(seq_step), .busy(busy));
  // expected {source, index} of a positive code under a route setting
  function automatic logic [6:0] exp_pos(input logic [4:0] c, input logic [3:0] r);
    logic [3:0] p;
    logic on;
    p = c[3:0];
    on = r[3] && ((p == ACIS_PIN_AN3 && r[0]) || (p == ACIS_PIN_AN0 && r[1]) ||
      (p == ACIS_PIN_AN6 && r[2]));
    if (c <= ACIS_POS_PIN_MAX) return on ? {ACIS_SRC_NONE, 4'h0} : {ACIS_SRC_PIN, p};
    if (c == ACIS_POS_TEMP) return {ACIS_SRC_TEMP, 4'h0};
    if (c < ACIS_POS_OA1 || c > ACIS_POS_OA3) return {ACIS_SRC_NONE, 4'h0};
    p = (c == ACIS_POS_OA1) ? ACIS_PIN_AN3 : (c == ACIS_POS_OA2) ? ACIS_PIN_AN0 : ACIS_PIN_AN6;
    return {r[c[1:0]] ? ACIS_SRC_OPAMP : ACIS_SRC_PIN, p};
  endfunction : exp_pos
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    // let an edge pass so the next call never re-raises the strobe in this time step
    @(posedge core_clk);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    // end on a rising edge so the next request starts right after it
    @(posedge core_clk);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle
  task automatic chk_mux(input logic [15:0] v, input logic [3:0] r);
    logic [6:0] ea, eb;
    ea = exp_pos(v[4:0], r);
    eb = exp_pos(v[12:8], r);
    chk({13'h0, mux_a_pos_src}, {13'h0, ea[6:4]});
    chk({13'h0, mux_b_pos_src}, {13'h0, eb[6:4]});
    if (ea[5:4] != 2'h0) chk({12'h0, mux_a_pos_idx}, {12'h0, ea[3:0]});
    if (eb[5:4] != 2'h0) chk({12'h0, mux_b_pos_idx}, {12'h0, eb[3:0]});
    chk({13'h0, mux_a_neg_src}, {13'h0, v[7] ? ACIS_SRC_PIN : ACIS_SRC_VREFL});
    chk({13'h0, mux_b_neg_src}, {13'h0, v[15] ? ACIS_SRC_PIN : ACIS_SRC_VREFL});
  endtask : chk_mux
  // bounded wait for the partner to issue its command
  task automatic step(input logic [1:0] k, input logic [3:0] g);
    int n;
    n = 0;
    go <= 1'h1;
    kind <= k;
    gap <= g;
    @(posedge core_clk);
    go <= 1'h0;
    @(posedge core_clk);
    #1;
    while (busy && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      errors++;
      tally_and_finish();
    end
    settle();
  endtask : step
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h2895FF10));
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    for (int a = 0; a < 3; a++) begin
      rd(4'(a), d);
      chk(d, ACIS_RESET_VAL);
    end
    rd(4'hF, d);
    chk(d, ACIS_UNMAPPED);
    // every positive code on both multiplexers, random route and spare bits
    for (int i = 0; i < 32; i++) begin
      rt = 4'($urandom);
      raw = 16'($urandom);
      raw[12:8] = 5'(i);
      raw[4:0] = ~5'(i);
      wr(ACIS_OFF_ROUTE, {12'h0, rt});
      wr(ACIS_OFF_CH0_SEL, raw);
      settle();
      rd(ACIS_OFF_CH0_SEL, d);
      chk(d, raw & ACIS_CH0_WMASK);
      chk_mux(raw, rt);
    end
    sel = raw & ACIS_CH0_WMASK;
    wr(ACIS_OFF_ROUTE, 16'h0000);
    // sequencer: first pass wraps the sum past 16 bits
    for (int i = 0; i < 3; i++) begin
      lit = (i == 0) ? 16'hFFFE : 16'($urandom);
      adj = (i == 0) ? 16'h801F : 16'($urandom);
      wr(ACIS_OFF_SEQ_CTRL, 16'h0001);
      rd(ACIS_OFF_STATUS, d);
      chk(d, 16'h0000);
      wr(ACIS_OFF_LITERAL, lit);
      wr(ACIS_OFF_ADJUST, adj);
      step(ACIS_STEP_CTRL, 4'h0);
      rd(ACIS_OFF_CH0_SEL, d);
      chk(d, sel);
      wr(ACIS_OFF_SEQ_CTRL, 16'h0003);
      rd(ACIS_OFF_STATUS, d);
      chk(d, 16'h0001);
      wr(ACIS_OFF_LITERAL, ~lit);
      rd(ACIS_OFF_LITERAL, d);
      chk(d, lit);
      step(ACIS_STEP_ADD, 4'($urandom));
      rd(ACIS_OFF_LITERAL, d);
      chk(d, lit + adj);
      step(ACIS_STEP_CTRL, 4'($urandom));
      sel = (lit + adj) & ACIS_CH0_WMASK;
      rd(ACIS_OFF_CH0_SEL, d);
      chk(d, sel);
      chk_mux(sel, 4'h0);
    end
    tally_and_finish();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
endmodule : tb_top
